// ---- verilog/iavr_top.sv ----
// Interrupt aggregation, mode gating, async wakeup, vector remap and
// flash-write stall. Peripheral flags come from logic on sys_clk; nmi_pin
// and the low-voltage events come from outside and are synchronised.
`timescale 1ns/1ns
`default_nettype none

module iavr_top (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Source flags
    input  wire logic [8:0]  fault_flag,
    input  wire logic        lowvolt_rise,
    input  wire logic        lowvolt_fall,
    input  wire logic        nmi_pin,
    input  wire logic [5:0]  channel_event_flag,
    input  wire logic        counter_overflow_flag,
    input  wire logic [1:0]  serial_overrun_flag,
    input  wire logic [1:0]  serial_noise_flag,
    input  wire logic [1:0]  serial_rx_full_flag,
    input  wire logic [1:0]  serial_break_flag,
    input  wire logic [1:0]  serial_rx_edge_flag,
    input  wire logic [1:0]  serial_tx_empty_flag,
    input  wire logic [1:0]  serial_tx_done_flag,
    input  wire logic [2:0]  port_irq_flag,
    input  wire logic [23:0] pin_irq_status,
    input  wire logic        conversion_done_flag,
    input  wire logic        clock_calendar_flag,
    input  wire logic        network_wakeup_flag,
    input  wire logic        network_sleep_wake_flag,
    input  wire logic        network_bus_error_flag,
    input  wire logic        network_arb_lost_flag,
    input  wire logic        network_err_passive_flag,
    input  wire logic        network_overrun_flag,
    input  wire logic        network_err_warn_flag,
    input  wire logic        network_rx_flag,
    input  wire logic        network_tx_flag,
    input  wire logic [1:0]  timer_irq_flag,
    input  wire logic        watchdog_wake,
    // System state
    input  wire logic [1:0]  work_mode,
    input  wire logic        sleep_mode,
    input  wire logic        flash_wr_start,
    input  wire logic        flash_wr_ok,
    // Core side
    input  wire logic [31:0] cpu_addr_in,
    output logic      [31:0] irq_line,
    output logic             nmi_out,
    output logic             wake_req,
    output logic             cpu_hold,
    output logic      [31:0] cpu_addr_out,
    output logic      [1:0]  cpu_region
);
    logic [31:0] mode_en;
    logic [8:0]  fault_en;
    logic        lowvolt_rise_irq_en;
    logic        lowvolt_fall_irq_en;
    logic [3:0]  nmi_mode_en;
    logic [31:0] orig_lo;
    logic [31:0] orig_hi;
    logic [31:0] map_lo;
    logic [31:0] map_hi;
    logic        remap_en;
    logic [6:0]  wake_stat;
    logic [31:0] prio [iavr_pkg::PRIO_REGS];
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic        nmi_s;
    logic        lv_rise_s;
    logic        lv_fall_s;
    logic [31:0] raw_line;
    logic [6:0]  wake_src;
    logic        wake_raw;
    logic        bus_req;
    logic        bus_wr;
    logic [31:0] next_rdata;
    logic [31:0] remap_sum;
    logic        remap_hit;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Pins from outside the clock domain pass two flops first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {nmi_pin, lowvolt_fall, lowvolt_rise};
            sync_b <= sync_a;
        end
    end
    assign lv_rise_s = sync_b[0];
    assign lv_fall_s = sync_b[1];
    assign nmi_s     = sync_b[2];

    // Source to line mapping
    always_comb begin
        raw_line = 32'h0000_0000;
        raw_line[iavr_pkg::IRQ_SYS] = |(fault_flag & fault_en);
        raw_line[iavr_pkg::IRQ_LV] = (lv_rise_s & lowvolt_rise_irq_en)
                                   | (lv_fall_s & lowvolt_fall_irq_en);
        raw_line[iavr_pkg::IRQ_PWM_CH0 +: 6] = channel_event_flag;
        raw_line[iavr_pkg::IRQ_PWM_OVF] = counter_overflow_flag;
        for (int p = 0; p < 2; p++) begin
            raw_line[iavr_pkg::IRQ_SCI0_ERR + 3*p] =
                serial_overrun_flag[p] | serial_noise_flag[p];
            raw_line[iavr_pkg::IRQ_SCI0_ERR + 3*p + 1] =
                serial_rx_full_flag[p] | serial_break_flag[p]
                | serial_rx_edge_flag[p];
            raw_line[iavr_pkg::IRQ_SCI0_ERR + 3*p + 2] =
                serial_tx_empty_flag[p] | serial_tx_done_flag[p];
        end
        // pins merged, flags stay separate upstream
        // port flag or any pin flag
        raw_line[iavr_pkg::IRQ_GPIO] = (|port_irq_flag) | (|pin_irq_status);
        raw_line[iavr_pkg::IRQ_ADC] = conversion_done_flag;
        raw_line[iavr_pkg::IRQ_RTC] = clock_calendar_flag;
        raw_line[iavr_pkg::IRQ_TMR0 +: 2] = timer_irq_flag;
        raw_line[iavr_pkg::IRQ_NET_WAKE] = network_wakeup_flag
                                         | network_sleep_wake_flag;
        raw_line[iavr_pkg::IRQ_NET_ERR] = network_bus_error_flag
            | network_arb_lost_flag | network_err_passive_flag
            | network_overrun_flag | network_err_warn_flag;
        raw_line[iavr_pkg::IRQ_NET_RX] = network_rx_flag;
        raw_line[iavr_pkg::IRQ_NET_TX] = network_tx_flag;
    end

    // mode gate and unused lines forced low
    // level follows flags until cleared at source
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_line <= 32'h0000_0000;
        end else begin
            irq_line <= raw_line & mode_en & iavr_pkg::USED_LINES;
        end
    end

    // NMI passes only in enabled working modes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nmi_out <= 1'b0;
        end else begin
            nmi_out <= nmi_s & nmi_mode_en[work_mode];
        end
    end

    // raw sources, no clock needed to assert wake
    assign wake_src[iavr_pkg::WK_LV]   = lowvolt_rise | lowvolt_fall;
    assign wake_src[iavr_pkg::WK_NMI]  = nmi_pin;
    assign wake_src[iavr_pkg::WK_GPIO] = (|port_irq_flag)
                                       | (|pin_irq_status);
    assign wake_src[iavr_pkg::WK_NET]  = |raw_line[iavr_pkg::IRQ_NET_WAKE +: 4];
    assign wake_src[iavr_pkg::WK_SCI]  = |raw_line[iavr_pkg::IRQ_SCI0_ERR +: 6];
    assign wake_src[iavr_pkg::WK_RTC]  = clock_calendar_flag;
    assign wake_src[iavr_pkg::WK_WDT]  = watchdog_wake;
    assign wake_raw = sleep_mode & (|wake_src);

    // asynchronous set, released once the system leaves sleep
    always_ff @(posedge sys_clk or negedge nrst or posedge wake_raw) begin
        if (!nrst) begin
            wake_req <= 1'b0;
        end else if (wake_raw) begin
            wake_req <= 1'b1;
        end else if (!sleep_mode) begin
            wake_req <= 1'b0;
        end
    end

    // stall from write start until a successful write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_hold <= 1'b0;
        end else if (flash_wr_start) begin
            cpu_hold <= 1'b1;
        end else if (flash_wr_ok) begin
            cpu_hold <= 1'b0;
        end
    end

    // base plus offset, only if it lands inside the mapped window
    assign remap_sum = map_lo + (cpu_addr_in - orig_lo);
    assign remap_hit = remap_en && cpu_addr_in >= orig_lo
                       && cpu_addr_in <= orig_hi && remap_sum <= map_hi;

    // one cycle of latency on the translated address
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_addr_out <= 32'h0000_0000;
        end else begin
            cpu_addr_out <= remap_hit ? remap_sum : cpu_addr_in;
        end
    end

    // region: flash and info from the unmapped address, SRAM from the address presented to memory
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_region <= iavr_pkg::RGN_OTHER;
        end else if (!remap_hit && cpu_addr_in <= iavr_pkg::FLASH_HI) begin
            cpu_region <= iavr_pkg::RGN_FLASH;
        end else if (!remap_hit && cpu_addr_in >= iavr_pkg::INFO_LO
                     && cpu_addr_in <= iavr_pkg::INFO_HI) begin
            cpu_region <= iavr_pkg::RGN_INFO;
        end else if ((remap_hit ? remap_sum : cpu_addr_in)
                         >= iavr_pkg::SRAM_LO
                     && (remap_hit ? remap_sum : cpu_addr_in)
                         <= iavr_pkg::SRAM_HI) begin
            cpu_region <= iavr_pkg::RGN_SRAM;
        end else begin
            cpu_region <= iavr_pkg::RGN_OTHER;
        end
    end

    // Bus: ack one cycle after the request, dropped the cycle after
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // remap stays off until software writes 1 to bit 0 of the remap control register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_en             <= iavr_pkg::MODE_EN_RST;
            fault_en            <= iavr_pkg::FAULT_EN_RST;
            lowvolt_rise_irq_en <= iavr_pkg::LV_EN_RST[0];
            lowvolt_fall_irq_en <= iavr_pkg::LV_EN_RST[1];
            nmi_mode_en         <= iavr_pkg::NMI_EN_RST;
            orig_lo             <= iavr_pkg::ORIG_LO_RST;
            orig_hi             <= iavr_pkg::ORIG_HI_RST;
            map_lo              <= iavr_pkg::MAP_LO_RST;
            map_hi              <= iavr_pkg::MAP_HI_RST;
            remap_en            <= 1'b0;
        end else if (bus_wr) begin
            unique case (wb_adr_i)
                iavr_pkg::ADR_MODE_EN: begin
                    mode_en <= merge(mode_en, wb_dat_i, wb_sel_i)
                               & iavr_pkg::USED_LINES;
                end
                iavr_pkg::ADR_FAULT_EN: begin
                    if (wb_sel_i[0]) fault_en[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) fault_en[8] <= wb_dat_i[8];
                end
                iavr_pkg::ADR_LV_EN: begin
                    if (wb_sel_i[0]) begin
                        lowvolt_rise_irq_en <= wb_dat_i[0];
                        lowvolt_fall_irq_en <= wb_dat_i[1];
                    end
                end
                iavr_pkg::ADR_NMI_EN: begin
                    if (wb_sel_i[0]) nmi_mode_en <= wb_dat_i[3:0];
                end
                iavr_pkg::ADR_ORIG_LO: begin
                    orig_lo <= merge(orig_lo, wb_dat_i, wb_sel_i);
                end
                iavr_pkg::ADR_ORIG_HI: begin
                    orig_hi <= merge(orig_hi, wb_dat_i, wb_sel_i);
                end
                iavr_pkg::ADR_MAP_LO: begin
                    map_lo <= merge(map_lo, wb_dat_i, wb_sel_i);
                end
                iavr_pkg::ADR_MAP_HI: begin
                    map_hi <= merge(map_hi, wb_dat_i, wb_sel_i);
                end
                iavr_pkg::ADR_REMAP_CTRL: begin
                    if (wb_sel_i[0]) remap_en <= wb_dat_i[0];
                end
                default: begin
                end
            endcase
        end
    end

    // priority fields reset to the line number
    for (genvar g = 0; g < iavr_pkg::PRIO_REGS; g++) begin : g_prio
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                prio[g] <= {8'(4*g+3), 8'(4*g+2), 8'(4*g+1), 8'(4*g)};
            end else if (bus_wr && wb_adr_i ==
                         iavr_pkg::ADR_PRIO_BASE + 8'(4*g)) begin
                prio[g] <= merge(prio[g], wb_dat_i, wb_sel_i);
            end
        end
    end

    // Wake causes: set wins over a write-one clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_stat <= 7'h00;
        end else begin
            wake_stat <= (wake_stat
                & ~((bus_wr && wb_adr_i == iavr_pkg::ADR_WAKE_STAT
                     && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00))
                | (sleep_mode ? {wake_src[6:2], lv_rise_s | lv_fall_s,
                                 nmi_s} & 7'h7c | {5'h00, nmi_s,
                                 lv_rise_s | lv_fall_s} : 7'h00);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            iavr_pkg::ADR_MODE_EN:    next_rdata = mode_en;
            iavr_pkg::ADR_FAULT_EN:   next_rdata = {23'h0, fault_en};
            iavr_pkg::ADR_LV_EN:      next_rdata = {30'h0,
                lowvolt_fall_irq_en, lowvolt_rise_irq_en};
            iavr_pkg::ADR_NMI_EN:     next_rdata = {28'h0, nmi_mode_en};
            iavr_pkg::ADR_ORIG_LO:    next_rdata = orig_lo;
            iavr_pkg::ADR_ORIG_HI:    next_rdata = orig_hi;
            iavr_pkg::ADR_MAP_LO:     next_rdata = map_lo;
            iavr_pkg::ADR_MAP_HI:     next_rdata = map_hi;
            iavr_pkg::ADR_REMAP_CTRL: next_rdata = {31'h0, remap_en};
            iavr_pkg::ADR_LINE_STAT:  next_rdata = irq_line;
            iavr_pkg::ADR_WAKE_STAT:  next_rdata = {25'h0, wake_stat};
            default: begin
                if (wb_adr_i[7:5] == iavr_pkg::ADR_PRIO_BASE[7:5]) begin
                    next_rdata = prio[wb_adr_i[4:2]];
                end
            end
        endcase
    end

    a_gpio_line: assert property (@(posedge sys_clk) disable iff (!nrst)
        ((|pin_irq_status) && mode_en[iavr_pkg::IRQ_GPIO])
            |=> irq_line[iavr_pkg::IRQ_GPIO])
        else $error("gpio line not raised");

    a_unused_low: assert property (@(posedge sys_clk) disable iff (!nrst)
        (irq_line & ~iavr_pkg::USED_LINES) == 32'h0000_0000)
        else $error("unused line driven");

    a_fault_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        ((fault_flag & fault_en) == 9'h000) |=> !irq_line[iavr_pkg::IRQ_SYS])
        else $error("system line without enabled cause");

    a_lowvolt_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
        (lowvolt_rise && lowvolt_rise_irq_en && mode_en[iavr_pkg::IRQ_LV])
            [*4] |-> irq_line[iavr_pkg::IRQ_LV])
        else $error("low-voltage rise not forwarded");

    a_pwm_order: assert property (@(posedge sys_clk) disable iff (!nrst)
        (channel_event_flag[5] && mode_en[10]) |=> irq_line[10])
        else $error("channel 5 not on line 10");

    a_nmi_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        !nmi_mode_en[work_mode] |=> !nmi_out)
        else $error("nmi passed in masked mode");

    a_wake_async: assert property (@(posedge sys_clk) disable iff (!nrst)
        (sleep_mode && clock_calendar_flag) |-> ##1 wake_req)
        else $error("no wake from clock flag");

    a_hold_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        flash_wr_start |=> (cpu_hold until flash_wr_ok))
        else $error("hold not kept until write ok");

    a_remap_base: assert property (@(posedge sys_clk) disable iff (!nrst)
        (remap_en && cpu_addr_in == orig_lo && orig_hi >= orig_lo
         && map_hi >= map_lo) |=> cpu_addr_out == $past(map_lo))
        else $error("window base not remapped");

    a_remap_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        !remap_en |=> cpu_addr_out == $past(cpu_addr_in))
        else $error("address changed with remap off");

    a_orig_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (bus_wr && wb_adr_i == iavr_pkg::ADR_ORIG_LO && wb_sel_i == 4'hf)
            |=> orig_lo == $past(wb_dat_i))
        else $error("original base write lost");

endmodule // iavr_top

`default_nettype wire

// ---- verilog/iavr_pkg.sv ----
// Constants for the interrupt aggregation and vector remap block.
// Assumes a Wishbone master with 32-bit data and byte addresses.
package iavr_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADR_MODE_EN    = 8'h00;
    localparam logic [7:0]  ADR_FAULT_EN   = 8'h04;
    localparam logic [7:0]  ADR_LV_EN      = 8'h08;
    localparam logic [7:0]  ADR_NMI_EN     = 8'h0c;
    localparam logic [7:0]  ADR_ORIG_LO    = 8'h10;
    localparam logic [7:0]  ADR_ORIG_HI    = 8'h14;
    localparam logic [7:0]  ADR_MAP_LO     = 8'h18;
    localparam logic [7:0]  ADR_MAP_HI     = 8'h1c;
    localparam logic [7:0]  ADR_REMAP_CTRL = 8'h20;
    localparam logic [7:0]  ADR_LINE_STAT  = 8'h24;
    localparam logic [7:0]  ADR_WAKE_STAT  = 8'h28;
    localparam logic [7:0]  ADR_PRIO_BASE  = 8'h40;
    localparam int          PRIO_REGS      = 8;

    // Interrupt line numbers
    localparam int IRQ_SYS      = 1;
    localparam int IRQ_LV       = 4;
    localparam int IRQ_PWM_CH0  = 5;
    localparam int IRQ_PWM_OVF  = 11;
    localparam int IRQ_SCI0_ERR = 16;
    localparam int IRQ_GPIO     = 22;
    localparam int IRQ_ADC      = 23;
    localparam int IRQ_RTC      = 25;
    localparam int IRQ_NET_WAKE = 26;
    localparam int IRQ_NET_ERR  = 27;
    localparam int IRQ_NET_RX   = 28;
    localparam int IRQ_NET_TX   = 29;
    localparam int IRQ_TMR0     = 30;
    localparam logic [31:0] USED_LINES = 32'hfeff_0ff2;

    // System fault cause bit positions
    localparam int FLT_XTAL_INIT = 0;
    localparam int FLT_XTAL_CHK  = 1;
    localparam int FLT_NVR       = 2;
    localparam int FLT_FPROT     = 3;
    localparam int FLT_EPROT     = 4;
    localparam int FLT_F_ONE     = 5;
    localparam int FLT_F_TWO     = 6;
    localparam int FLT_E_ONE     = 7;
    localparam int FLT_E_TWO     = 8;

    // Wake status bit positions
    localparam int WK_LV   = 0;
    localparam int WK_NMI  = 1;
    localparam int WK_GPIO = 2;
    localparam int WK_NET  = 3;
    localparam int WK_SCI  = 4;
    localparam int WK_RTC  = 5;
    localparam int WK_WDT  = 6;

    // Reset values
    localparam logic [31:0] MODE_EN_RST  = USED_LINES;
    localparam logic [8:0]  FAULT_EN_RST = 9'h1ff;
    localparam logic [1:0]  LV_EN_RST    = 2'h0;
    localparam logic [3:0]  NMI_EN_RST   = 4'hf;
    localparam logic [31:0] ORIG_LO_RST  = 32'h0000_0000;
    localparam logic [31:0] ORIG_HI_RST  = 32'h0001_7fff;
    localparam logic [31:0] MAP_LO_RST   = 32'h2000_0000;
    localparam logic [31:0] MAP_HI_RST   = 32'h2000_0fff;

    // Address map windows
    localparam logic [31:0] FLASH_LO = 32'h0000_0000;
    localparam logic [31:0] FLASH_HI = 32'h0001_7fff;
    localparam logic [31:0] INFO_LO  = 32'h0001_8000;
    localparam logic [31:0] INFO_HI  = 32'h0001_8fff;
    localparam logic [31:0] SRAM_LO  = 32'h2000_0000;
    localparam logic [31:0] SRAM_HI  = 32'h2000_0fff;

    // Region codes on cpu_region
    localparam logic [1:0] RGN_OTHER = 2'h0;
    localparam logic [1:0] RGN_FLASH = 2'h1;
    localparam logic [1:0] RGN_INFO  = 2'h2;
    localparam logic [1:0] RGN_SRAM  = 2'h3;
endpackage

// ---- testbench/iavr_core_model.sv ----
// Core model: puts fetch addresses on the remap input.
// Assumes callers enter fetch just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module iavr_core_model (
    input  wire logic        sys_clk,
    input  wire logic        cpu_hold,
    output var  logic [31:0] cpu_addr_in
);
    initial cpu_addr_in = 32'h0;
    task automatic fetch(input logic [31:0] a);
        while (cpu_hold !== 1'b0) @(posedge sys_clk);
        cpu_addr_in <= a;
    endtask
endmodule // iavr_core_model
`default_nettype wire

// ---- testbench/test_irq_aggregation_vector_remap.sv ----
// Bench: registers, line mapping, remap, flash hold, wake, nmi.
// Assumes iavr_top and the core model share one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module test_irq_aggregation_vector_remap;
    logic sys_clk = '0, nrst = '0, wb_cyc_i = '0, wb_stb_i = '0;
    logic wb_we_i = '0, lowvolt_rise = '0, lowvolt_fall = '0, nmi_pin = '0;
    logic counter_overflow_flag = '0, conversion_done_flag = '0;
    logic clock_calendar_flag = '0, network_wakeup_flag = '0;
    logic network_sleep_wake_flag = '0, network_bus_error_flag = '0;
    logic network_arb_lost_flag = '0, network_err_passive_flag = '0;
    logic network_overrun_flag = '0, network_err_warn_flag = '0;
    logic network_rx_flag = '0, network_tx_flag = '0, watchdog_wake = '0;
    logic flash_wr_start = '0, flash_wr_ok = '0, sleep_mode = '0;
    logic [1:0] serial_overrun_flag = '0, serial_noise_flag = '0;
    logic [1:0] serial_rx_full_flag = '0, serial_break_flag = '0;
    logic [1:0] serial_rx_edge_flag = '0, serial_tx_empty_flag = '0;
    logic [1:0] serial_tx_done_flag = '0, timer_irq_flag = '0;
    logic [1:0] work_mode = '0, cpu_region;
    logic [2:0] port_irq_flag = '0;
    logic [3:0] wb_sel_i = '0;
    logic [5:0] channel_event_flag = '0;
    logic [7:0] wb_adr_i = '0;
    logic [8:0] fault_flag = '0;
    logic [23:0] pin_irq_status = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, irq_line, cpu_addr_in;
    logic [31:0] cpu_addr_out, q;
    logic wb_ack_o, nmi_out, wake_req, cpu_hold;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    logic [7:0] ra [4] = '{8'h00, 8'h14, 8'h44, 8'h30};
    logic [31:0] rv [4] = '{32'hfeff_0ff2, 32'h1_7fff, 32'h0706_0504, '0};

    iavr_top i_iavr_top (.*);
    iavr_core_model i_iavr_core_model (.*);

    initial forever #20 sys_clk = ~sys_clk;

    task conclude;
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for ack itself; only the cycle ceiling ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 4'hf};
        {wb_adr_i, wb_dat_i} <= {a, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= '0;
        @(posedge sys_clk);
    endtask

    task lc(input logic [31:0] e);
        @(posedge sys_clk);
        #1 cmp(irq_line, e);
        @(posedge sys_clk);
    endtask

    task rm(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        i_iavr_core_model.fetch(a);
        @(posedge sys_clk);
        #1 cmp(cpu_addr_out, e);
        cmp(32'(cpu_region), 32'(r));
        @(posedge sys_clk);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        foreach (ra[i]) begin
            wb(1'b0, ra[i], '0);
            cmp(q, rv[i]);
        end
        wb(1'b1, 8'h00, '1);
        wb(1'b0, 8'h00, '0);
        cmp(q, 32'hfeff_0ff2);
        wb(1'b1, 8'h04, 32'h0ff);
        fault_flag <= 9'h100;
        lc('0);
        fault_flag <= 9'h001;
        lc(32'h2);
        fault_flag <= '0;
        for (int i = 0; i < 6; i++) begin
            channel_event_flag <= 6'h1 << i;
            lc(32'h20 << i);
        end
        channel_event_flag <= '0;
        counter_overflow_flag <= 1'b1;
        lc(32'h800);
        counter_overflow_flag <= 1'b0;
        serial_tx_done_flag <= 2'h2;
        lc(32'h20_0000);
        serial_tx_done_flag <= '0;
        pin_irq_status <= 24'h80_0000;
        lc(32'h40_0000);
        wb(1'b1, 8'h00, 32'hfebf_0ff2);
        lc('0);
        pin_irq_status <= '0;
        {network_bus_error_flag, conversion_done_flag} <= 2'h3;
        timer_irq_flag <= 2'h2;
        lc(32'h8880_0000);
        {network_bus_error_flag, conversion_done_flag} <= 2'h0;
        timer_irq_flag <= '0;
        // windows stay at their programmed reset values before enabling
        wb(1'b1, 8'h20, 32'h1);
        // vector 0x8 redirected into SRAM; 0x1000 lands past map_hi and stays in flash, info passes unchanged
        rm(32'h8, 32'h2000_0008, 2'h3);
        rm(32'h1000, 32'h1000, 2'h1);
        rm(32'h1_8010, 32'h1_8010, 2'h2);
        flash_wr_start <= 1'b1;
        @(posedge sys_clk);
        flash_wr_start <= 1'b0;
        #1 cmp(32'(cpu_hold), 32'h1);
        @(posedge sys_clk);
        flash_wr_ok <= 1'b1;
        @(posedge sys_clk);
        flash_wr_ok <= 1'b0;
        #1 cmp(32'(cpu_hold), '0);
        @(posedge sys_clk);
        {sleep_mode, watchdog_wake} <= 2'h3;
        #1 cmp(32'(wake_req), 32'h1);
        @(posedge sys_clk);
        {sleep_mode, watchdog_wake} <= 2'h0;
        repeat (2) @(posedge sys_clk);
        #1 cmp(32'(wake_req), '0);
        @(posedge sys_clk);
        wb(1'b0, 8'h28, '0);
        cmp(q, 32'h40);
        wb(1'b1, 8'h08, 32'h1);
        lowvolt_rise <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 cmp(irq_line, 32'h10);
        @(posedge sys_clk);
        lowvolt_rise <= 1'b0;
        nmi_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 cmp(32'(nmi_out), 32'h1);
        @(posedge sys_clk);
        wb(1'b1, 8'h0c, '0);
        @(posedge sys_clk);
        #1 cmp(32'(nmi_out), '0);
        conclude();
    end
endmodule // test_irq_aggregation_vector_remap
`default_nettype wire
